//--- pci_bus_ctl_pkg.sv
// Register map, field positions, reset values and carrier types of the PCI bus control register set.
package pci_bus_ctl_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFS_BUS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_RETRY_LIMIT = 12'h080;
  localparam logic [11:0] OFS_SCRATCH = 12'h100;
  localparam logic [11:0] OFS_ERROR_SUMMARY = 12'h180;
  localparam logic [31:0] RST_BUS_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_RETRY_LIMIT = 32'h0000_0000;
  localparam logic [31:0] RST_SCRATCH = 32'h0000_0000;
  localparam logic [31:0] RST_ERROR_SUMMARY = 32'h0000_0000;
  localparam logic [31:0] CTL_WMASK = 32'h1fff_ffff;
  localparam logic [31:0] RETRY_WMASK = 32'h00ff_ffff;

  // ---------------------------------------------------------------------------
  // Bus control field positions
  // ---------------------------------------------------------------------------
  localparam int CTL_ARB_HI = 28;
  localparam int CTL_ARB_LO = 27;
  localparam int CTL_MAP_HI = 26;
  localparam int CTL_MAP_LO = 25;
  localparam int CTL_UPBUF_HI = 24;
  localparam int CTL_UPBUF_LO = 23;
  localparam int CTL_PF_SIZE = 22;
  localparam int CTL_PF_EN = 21;
  localparam int CTL_BURST = 20;
  localparam int CTL_EXT_DIS = 19;
  localparam int CTL_MEM_EXT_HI = 18;
  localparam int CTL_MEM_EXT_LO = 14;
  localparam int CTL_IO_EXT_HI = 13;
  localparam int CTL_IO_EXT_LO = 9;
  localparam int CTL_CUT_EN = 8;
  localparam int CTL_CUT_THR_HI = 7;
  localparam int CTL_CUT_THR_LO = 4;
  localparam int CTL_PCI_RST = 3;
  localparam int CTL_BLK_SIZE = 2;
  localparam int CTL_CFG_HI = 1;
  localparam int CTL_CFG_LO = 0;

  // ---------------------------------------------------------------------------
  // Error summary field positions and masks
  // ---------------------------------------------------------------------------
  localparam int ERR_SERR = 18;
  localparam int ERR_LATENCY = 17;
  localparam int ERR_MAP_PAR_CPU = 16;
  localparam int ERR_ILL_CSR = 15;
  localparam int ERR_NXM = 14;
  localparam int ERR_TGT_DISC = 13;
  localparam int ERR_TGT_ABORT = 12;
  localparam int ERR_WR_PAR = 11;
  localparam int ERR_DATA_PAR = 10;
  localparam int ERR_ADDR_PAR = 9;
  localparam int ERR_MAP_INV = 8;
  localparam int ERR_HOSE_HI = 7;
  localparam int ERR_HOSE_LO = 1;
  localparam int ERR_SUM = 0;
  localparam logic [31:0] ERR_MASK = 32'h0007_ffff;
  localparam logic [31:0] ERR_FIRST_ONLY = 32'h0001_c000;
  localparam logic [31:0] ERR_IRQ_MASK = 32'h0005_fffe;

  // ---------------------------------------------------------------------------
  // Decoded values and timing counts
  // ---------------------------------------------------------------------------
  localparam logic [1:0] MAP_256K = 2'h1;
  localparam logic [1:0] MAP_512K = 2'h3;
  localparam logic [4:0] MAP_BITS_128K = 5'h0f;
  localparam logic [4:0] MAP_BITS_256K = 5'h10;
  localparam logic [4:0] MAP_BITS_512K = 5'h11;
  localparam logic [2:0] UPBUF_CODE0 = 3'h4;
  localparam logic [2:0] PF_BLOCKS_LARGE = 3'h4;
  localparam logic [2:0] PF_BLOCKS_SMALL = 3'h2;
  localparam logic [4:0] BURST_LW_64B = 5'h10;
  localparam logic [4:0] BURST_LW_32B = 5'h08;
  localparam logic [3:0] LAT_MAX_CYCLES = 4'h8;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {SPACE_DENSE, SPACE_SPARSE_MEM, SPACE_SPARSE_IO, SPACE_CONFIG} addr_space_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } csr_req_t;

  typedef struct packed {
    logic rvalid;
    logic [31:0] rdata;
  } csr_rsp_t;

  typedef struct packed {
    logic map_par_cpu;
    logic nxm;
    logic tgt_abort;
    logic wr_par;
    logic data_par;
    logic addr_par;
    logic map_inv;
    logic [6:0] hose;
  } err_evt_t;

  typedef struct packed {
    logic [4:0] map_index_bits;
    logic [2:0] up_credits;
    logic [2:0] pf_blocks;
    logic burst_all;
    logic [4:0] max_lw;
  } cfg_out_t;

endpackage

//--- pci_rr_arbiter.sv
// Round-robin arbiter for the request lines of the PCI bus agents.
`timescale 1ns/1ps
module pci_rr_arbiter #(
  parameter int AGENTS = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Requests and grants
  input wire logic [AGENTS-1:0] req,
  output logic [AGENTS-1:0] gnt
);

  localparam int PW = (AGENTS > 1) ? $clog2(AGENTS) : 1;

  logic [PW-1:0] last;
  logic [PW-1:0] next_last;
  logic [AGENTS-1:0] next_gnt;

  // A grant is held while its request stays; otherwise the search starts after the last winner.
  always_comb begin
    int idx;
    logic found;
    idx = 0;
    found = 1'b0;
    next_gnt = '0;
    next_last = last;
    if (|(gnt & req)) begin
      next_gnt = gnt;
    end else begin
      for (int i = 1; i <= AGENTS; i++) begin
        idx = (int'(last) + i) % AGENTS;
        if (!found && req[idx]) begin
          found = 1'b1;
          next_gnt[idx] = 1'b1;
          next_last = idx[PW-1:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      gnt <= '0;
      last <= '0;
    end else begin
      gnt <= next_gnt;
      last <= next_last;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_gnt_onehot: assert property ($onehot0(gnt)) else $error("more than one grant");
  a_gnt_to_req: assert property (gnt != '0 |-> ##0 (gnt & $past(req)) != '0) else $error("grant without request");

endmodule

//--- pci_bus_ctl.sv
// Per-bus control, retry limit, scratch and error summary registers of the hose-to-bus controller.
//
// Operation
// - Round-robin arbitration; arbitration field written zero.
// - Map RAM size field sizes translation lookups.
// - Outstanding upstream packets never exceed buffer count.
// - Prefetch four extra blocks if set, else two.
// - Prefetch on memory read multiple only when enabled.
// - Burst bit sends all read-multiple packets per win.
// - Extension disable passes hose addresses unchanged.
// - Sparse memory upper address from memory extension.
// - Sparse I/O upper address from I/O extension.
// - Cut-through forwards read data before full arrival.
// - Unaligned reads wait for threshold longwords first.
// - Bus reset output follows write-only reset bit.
// - Block size bit limits bursts to 32 bytes.
// - Config cycle type drives address bits one, zero.
// - Retry limit exceeded or target abort flag errors.
// - Scratch word has no side effects.
// - Interrupt only on first error other than latency into summary.
// - System error pin and address parity set flags.
// - Target latency over eight cycles sets monitor flag.
// - Three error flags exist only on first bus.
// - Flag parity and invalid entries; capture failing address.
// - Error bits clear only where one written.
// - Summary bit reads one when any error set.
`timescale 1ns/1ps
module pci_bus_ctl #(
  parameter bit FIRST_BUS = 1'b1,
  parameter int AGENTS = 4,
  parameter int RETRY_W = 24
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // CSR packets from the hose
  input pci_bus_ctl_pkg::csr_req_t csr_req,
  output pci_bus_ctl_pkg::csr_rsp_t csr_rsp,
  // PCI arbitration
  input wire logic [AGENTS-1:0] pci_req,
  output logic [AGENTS-1:0] pci_gnt,
  // PCI pins
  input wire logic serr_n,
  output logic pci_reset_n,
  // Error events from the bus and hose logic
  input pci_bus_ctl_pkg::err_evt_t err_evt,
  input wire logic [31:0] dma_fail_addr,
  output logic [31:0] fail_addr,
  // Outbound address translation
  input wire logic xlat_valid,
  input pci_bus_ctl_pkg::addr_space_t xlat_space,
  input wire logic [31:0] xlat_addr,
  output logic pci_addr_valid,
  output logic [31:0] pci_addr,
  // Upstream packet credits
  input wire logic up_pkt_send,
  input wire logic up_buf_free,
  output logic up_credit_avail,
  // DMA read cut-through
  input wire logic [4:0] rd_lw_count,
  input wire logic rd_all_arrived,
  input wire logic rd_aligned64,
  output logic rd_start_ok,
  // Master retry and target latency
  input wire logic tgt_disconnect,
  input wire logic burst_done,
  input wire logic tgt_burst_active,
  input wire logic tgt_lw_xfer,
  // Decoded configuration and interrupt
  output pci_bus_ctl_pkg::cfg_out_t cfg,
  output logic err_irq
);
  import pci_bus_ctl_pkg::*;

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [31:0] ctl, next_ctl;
  logic [31:0] retry_limit, next_retry_limit;
  logic [31:0] scratch, next_scratch;
  logic [31:0] err, next_err;
  logic [31:0] next_fail_addr;
  csr_rsp_t next_csr_rsp;
  logic next_err_irq, next_pci_reset_n;
  logic [31:0] err_set, err_clr;
  logic wr_ctl, wr_retry, wr_scratch, wr_err, addr_ok;

  // ---------------------------------------------------------------------------
  // Pin synchroniser for the system error line
  // ---------------------------------------------------------------------------
  logic serr_s1, serr_s2, serr_s3, serr_level, next_serr_level;

  always_comb begin
    next_serr_level = (serr_s2 == serr_s3) ? serr_s3 : serr_level;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      serr_s1 <= 1'b1;
      serr_s2 <= 1'b1;
      serr_s3 <= 1'b1;
      serr_level <= 1'b1;
    end else begin
      serr_s1 <= serr_n;
      serr_s2 <= serr_s1;
      serr_s3 <= serr_s2;
      serr_level <= next_serr_level;
    end
  end

  // ---------------------------------------------------------------------------
  // Retry, latency and credit counters
  // ---------------------------------------------------------------------------
  logic [RETRY_W-1:0] retry_cnt, next_retry_cnt;
  logic retry_exceeded;
  logic [3:0] lat_cnt, next_lat_cnt;
  logic lat_over;
  logic [2:0] outstanding, next_outstanding;
  logic [2:0] credit_limit;
  logic send_ok;

  always_comb begin
    credit_limit = (ctl[CTL_UPBUF_HI:CTL_UPBUF_LO] == 2'h0) ? UPBUF_CODE0 : {1'b0, ctl[CTL_UPBUF_HI:CTL_UPBUF_LO]};
    send_ok = up_pkt_send && up_credit_avail;
    next_outstanding = outstanding;
    if (send_ok && !(up_buf_free && outstanding != 3'h0)) begin
      next_outstanding = outstanding + 3'h1;
    end else if (!send_ok && up_buf_free && outstanding != 3'h0) begin
      next_outstanding = outstanding - 3'h1;
    end
    retry_exceeded = 1'b0;
    next_retry_cnt = retry_cnt;
    if (burst_done) begin
      next_retry_cnt = '0;
    end else if (tgt_disconnect) begin
      if (retry_cnt >= retry_limit[RETRY_W-1:0]) begin
        retry_exceeded = 1'b1;
        next_retry_cnt = '0;
      end else begin
        next_retry_cnt = retry_cnt + 1'b1;
      end
    end
    lat_over = 1'b0;
    next_lat_cnt = 4'h0;
    if (tgt_burst_active && !tgt_lw_xfer) begin
      if (lat_cnt == LAT_MAX_CYCLES) begin
        lat_over = 1'b1;
        next_lat_cnt = lat_cnt;
      end else begin
        next_lat_cnt = lat_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      retry_cnt <= '0;
      lat_cnt <= 4'h0;
      outstanding <= 3'h0;
      up_credit_avail <= 1'b0;
    end else begin
      retry_cnt <= next_retry_cnt;
      lat_cnt <= next_lat_cnt;
      outstanding <= next_outstanding;
      up_credit_avail <= next_outstanding < credit_limit;
    end
  end

  // ---------------------------------------------------------------------------
  // CSR access and error summary
  // ---------------------------------------------------------------------------
  always_comb begin
    wr_ctl = csr_req.valid && csr_req.write && csr_req.addr == OFS_BUS_CONTROL;
    wr_retry = csr_req.valid && csr_req.write && csr_req.addr == OFS_RETRY_LIMIT;
    wr_scratch = csr_req.valid && csr_req.write && csr_req.addr == OFS_SCRATCH;
    wr_err = csr_req.valid && csr_req.write && csr_req.addr == OFS_ERROR_SUMMARY;
    addr_ok = csr_req.addr == OFS_BUS_CONTROL || csr_req.addr == OFS_RETRY_LIMIT ||
              csr_req.addr == OFS_SCRATCH || csr_req.addr == OFS_ERROR_SUMMARY;
    next_ctl = wr_ctl ? (csr_req.wdata & CTL_WMASK) : ctl;
    next_retry_limit = wr_retry ? (csr_req.wdata & RETRY_WMASK) : retry_limit;
    next_scratch = wr_scratch ? csr_req.wdata : scratch;
    next_csr_rsp.rvalid = csr_req.valid && !csr_req.write;
    next_csr_rsp.rdata = 32'h0000_0000;
    if (csr_req.valid && !csr_req.write) begin
      unique case (csr_req.addr)
        OFS_BUS_CONTROL: next_csr_rsp.rdata = ctl & ~(32'h1 << CTL_PCI_RST);
        OFS_RETRY_LIMIT: next_csr_rsp.rdata = retry_limit;
        OFS_SCRATCH: next_csr_rsp.rdata = scratch;
        OFS_ERROR_SUMMARY: next_csr_rsp.rdata = err;
        default: next_csr_rsp.rdata = 32'h0000_0000;
      endcase
    end
    err_set = 32'h0000_0000;
    err_set[ERR_SERR] = !serr_level;
    err_set[ERR_LATENCY] = lat_over;
    err_set[ERR_MAP_PAR_CPU] = err_evt.map_par_cpu;
    err_set[ERR_ILL_CSR] = csr_req.valid && !addr_ok;
    err_set[ERR_NXM] = err_evt.nxm;
    err_set[ERR_TGT_DISC] = retry_exceeded;
    err_set[ERR_TGT_ABORT] = err_evt.tgt_abort;
    err_set[ERR_WR_PAR] = err_evt.wr_par;
    err_set[ERR_DATA_PAR] = err_evt.data_par;
    err_set[ERR_ADDR_PAR] = err_evt.addr_par;
    err_set[ERR_MAP_INV] = err_evt.map_inv;
    err_set[ERR_HOSE_HI:ERR_HOSE_LO] = err_evt.hose;
    err_set = FIRST_BUS ? err_set : (err_set & ~ERR_FIRST_ONLY);
    err_clr = wr_err ? csr_req.wdata : 32'h0000_0000;
    next_err = ((err & ~err_clr) | err_set) & ERR_MASK;
    next_err[ERR_SUM] = |next_err[ERR_SERR:ERR_HOSE_LO];
    next_err_irq = (|(next_err & ERR_IRQ_MASK)) && !(|(err & ERR_IRQ_MASK));
    next_fail_addr = (err_evt.wr_par || err_evt.map_inv) ? dma_fail_addr : fail_addr;
    next_pci_reset_n = !next_ctl[CTL_PCI_RST];
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctl <= RST_BUS_CONTROL;
      retry_limit <= RST_RETRY_LIMIT;
      scratch <= RST_SCRATCH;
      err <= RST_ERROR_SUMMARY;
      fail_addr <= 32'h0000_0000;
      csr_rsp <= '0;
      err_irq <= 1'b0;
      pci_reset_n <= 1'b1;
    end else begin
      ctl <= next_ctl;
      retry_limit <= next_retry_limit;
      scratch <= next_scratch;
      err <= next_err;
      fail_addr <= next_fail_addr;
      csr_rsp <= next_csr_rsp;
      err_irq <= next_err_irq;
      pci_reset_n <= next_pci_reset_n;
    end
  end

  // ---------------------------------------------------------------------------
  // Decoded configuration, translation and cut-through
  // ---------------------------------------------------------------------------
  cfg_out_t next_cfg;
  logic [31:0] next_pci_addr;
  logic next_rd_start_ok;

  always_comb begin
    unique case (ctl[CTL_MAP_HI:CTL_MAP_LO])
      MAP_256K: next_cfg.map_index_bits = MAP_BITS_256K;
      MAP_512K: next_cfg.map_index_bits = MAP_BITS_512K;
      default: next_cfg.map_index_bits = MAP_BITS_128K;
    endcase
    next_cfg.up_credits = credit_limit;
    next_cfg.pf_blocks = !ctl[CTL_PF_EN] ? 3'h0 : (ctl[CTL_PF_SIZE] ? PF_BLOCKS_LARGE : PF_BLOCKS_SMALL);
    next_cfg.burst_all = ctl[CTL_BURST] && ctl[CTL_PF_EN];
    next_cfg.max_lw = ctl[CTL_BLK_SIZE] ? BURST_LW_32B : BURST_LW_64B;
    next_pci_addr = xlat_addr;
    unique case (xlat_space)
      SPACE_SPARSE_MEM: begin
        if (!ctl[CTL_EXT_DIS] && |xlat_addr[31:29]) begin
          next_pci_addr[31:27] = ctl[CTL_MEM_EXT_HI:CTL_MEM_EXT_LO];
        end
      end
      SPACE_SPARSE_IO: begin
        if (!ctl[CTL_EXT_DIS] && |xlat_addr[31:29]) begin
          next_pci_addr[31:27] = ctl[CTL_IO_EXT_HI:CTL_IO_EXT_LO];
        end
      end
      SPACE_CONFIG: next_pci_addr[1:0] = ctl[CTL_CFG_HI:CTL_CFG_LO];
      SPACE_DENSE: next_pci_addr = xlat_addr;
    endcase
    next_rd_start_ok = rd_all_arrived;
    if (ctl[CTL_CUT_EN] && rd_lw_count != 5'h00) begin
      if (rd_aligned64 || rd_lw_count >= {1'b0, ctl[CTL_CUT_THR_HI:CTL_CUT_THR_LO]}) begin
        next_rd_start_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cfg <= '0;
      pci_addr <= 32'h0000_0000;
      pci_addr_valid <= 1'b0;
      rd_start_ok <= 1'b0;
    end else begin
      cfg <= next_cfg;
      pci_addr <= next_pci_addr;
      pci_addr_valid <= xlat_valid;
      rd_start_ok <= next_rd_start_ok;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus arbitration
  // ---------------------------------------------------------------------------
  pci_rr_arbiter #(.AGENTS(AGENTS)) u_arb (
    .core_clk(core_clk),
    .nrst(nrst),
    .req(pci_req),
    .gnt(pci_gnt)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_serr_held;
    !serr_n [*5];
  endsequence
  sequence s_err_write_clear;
    wr_err && csr_req.wdata[ERR_TGT_ABORT] && !err_evt.tgt_abort;
  endsequence

  a_scratch_quiet: assert property (!wr_scratch |=> $stable(scratch)) else $error("scratch changed");
  a_reset_pin: assert property (wr_ctl |=> pci_reset_n == !$past(csr_req.wdata[CTL_PCI_RST])) else $error("reset pin");
  a_w1c_clear: assert property (s_err_write_clear |=> !err[ERR_TGT_ABORT]) else $error("w1c failed");
  a_zero_keeps: assert property (wr_err && !csr_req.wdata[ERR_NXM] && err[ERR_NXM] |=> err[ERR_NXM]) else $error("zero cleared");
  a_sum_bit: assert property (err[ERR_SUM] == |err[ERR_SERR:ERR_HOSE_LO]) else $error("summary bit wrong");
  a_first_only: assert property (!FIRST_BUS |-> (err & ERR_FIRST_ONLY) == 32'h0) else $error("first-bus flag set");
  a_irq_first: assert property (err_irq |-> $past((err & ERR_IRQ_MASK) == 32'h0)) else $error("irq not first");
  a_latency_noirq: assert property (
    lat_over && (err & ERR_IRQ_MASK) == 32'h0 && err_set == 32'h20000 |=> !err_irq)
    else $error("latency raised irq");
  a_credit_limit: assert property (outstanding <= credit_limit || $changed(credit_limit)) else $error("credits over");
  a_retry_err: assert property (
    tgt_disconnect && !burst_done && retry_cnt >= retry_limit[RETRY_W-1:0] |=> err[ERR_TGT_DISC])
    else $error("retry limit missed");
  a_serr_flag: assert property (s_serr_held |-> ##[0:1] err[ERR_SERR]) else $error("serr not flagged");
  a_cfg_type: assert property (xlat_valid && xlat_space == SPACE_CONFIG |=> pci_addr[1:0] == $past(ctl[1:0]))
    else $error("config type");

endmodule

//--- pci_agents_model.sv
// Behavioural model of the PCI agents that sit on the far side of the bus controller.
`timescale 1ns/1ps
module pci_agents_model (
  // Clock
  input wire logic core_clk,
  // Bus arbitration
  input wire logic [3:0] gnt,
  output logic [3:0] req,
  // System error pin
  input wire logic serr_fire,
  output logic serr_n
);
  logic [2:0] low_left = 3'h0;
  initial req = 4'h0;
  // Every agent asks again one cycle after its grant so that all of them compete.
  always @(negedge core_clk) begin
    req <= ~gnt;
  end
  always @(posedge core_clk) begin
    if (serr_fire) begin
      low_left <= 3'h6;
    end else if (low_left != 3'h0) begin
      low_left <= low_left - 3'h1;
    end
  end
  // The pin has a pull-up, so it returns high when no agent pulls it.
  assign serr_n = (low_left == 3'h0);
endmodule

//--- pci_bus_ctl_tb.sv
// Self-checking testbench of the PCI bus control and error register set.
`timescale 1ns/1ps
module pci_bus_ctl_tb;
  import pci_bus_ctl_pkg::*;
  logic core_clk = 1'h0, nrst = 1'h0, serr_n, serr_fire = 1'h0, pci_reset_n, err_irq;
  csr_req_t csr_req = '0;
  csr_rsp_t csr_rsp, rsp_b;
  logic [3:0] pci_req, pci_gnt, seen_gnt = 4'h0;
  err_evt_t err_evt = '0;
  logic [31:0] dma_fail_addr = 32'h0, fail_addr, xlat_addr = 32'h0, pci_addr, rnd;
  addr_space_t xlat_space = SPACE_DENSE;
  logic xlat_valid = 1'h0, pci_addr_valid, up_pkt_send = 1'h0, up_buf_free = 1'h0, up_credit_avail;
  logic rd_all_arrived = 1'h0, rd_aligned64 = 1'h0, rd_start_ok, tgt_disconnect = 1'h0;
  logic burst_done = 1'h0, tgt_burst_active = 1'h0, tgt_lw_xfer = 1'h0;
  logic [4:0] rd_lw_count = 5'h0;
  cfg_out_t cfg;
  logic [31:0] exp_q[$];
  logic [31:0] last_b = 32'h0;
  integer num_errors = 0, num_checks = 0, cycles = 0, irq_cnt = 0, seed = 32'h018a;

  pci_bus_ctl dut (.*);
  pci_agents_model agents (.core_clk(core_clk), .gnt(pci_gnt), .req(pci_req), .serr_fire(serr_fire),
    .serr_n(serr_n));
  // A second bus instance shows that the first-bus-only error flags stay clear there.
  pci_bus_ctl #(.FIRST_BUS(1'b0)) dut_b (.*, .csr_rsp(rsp_b), .pci_gnt(), .pci_reset_n(), .fail_addr(),
    .pci_addr_valid(), .pci_addr(), .up_credit_avail(), .rd_start_ok(), .cfg(), .err_irq());

  always #50 core_clk = ~core_clk;

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // A read notes its expected data for the watcher below.
  task automatic csr(input logic wr, input logic [11:0] a, input logic [31:0] d);
    csr_req = {1'h1, wr, a, d};
    if (!wr) exp_q.push_back(d);
    tick(1);
    csr_req = '0;
    tick(1);
  endtask
  task automatic xlat(input addr_space_t sp, input logic [31:0] a, input logic [31:0] e);
    xlat_space = sp;
    xlat_addr = a;
    xlat_valid = 1'h1;
    tick(1);
    xlat_valid = 1'h0;
    check({31'h0, pci_addr_valid}, 32'h1);
    check(pci_addr, e);
  endtask
  task automatic cut_loop(input logic en);
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      rd_lw_count = rnd[4:0];
      rd_all_arrived = rnd[5] & rnd[6];
      rd_aligned64 = rnd[7];
      tick(1);
      check(rd_start_ok, rd_all_arrived | (en && rd_lw_count != 5'h0 && (rd_aligned64 || rd_lw_count >= 5'h3)));
    end
  endtask
  task automatic pulse_disc(input int n);
    repeat (n) begin
      tgt_disconnect = 1'h1;
      tick(1);
      tgt_disconnect = 1'h0;
      tick(1);
    end
  endtask

  always @(negedge core_clk) begin
    cycles++;
    seen_gnt = seen_gnt | pci_gnt;
    if (err_irq === 1'h1) irq_cnt++;
    if (rsp_b.rvalid === 1'h1) last_b = rsp_b.rdata;
    if (csr_rsp.rvalid === 1'h1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check(csr_rsp.rdata, exp_q.pop_front());
    end
    if (cycles == 11000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    tick(4);
    nrst = 1'h1;
    csr(1'h0, OFS_BUS_CONTROL, RST_BUS_CONTROL);
    csr(1'h0, OFS_ERROR_SUMMARY, RST_ERROR_SUMMARY);
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      csr(1'h1, OFS_SCRATCH, rnd);
      csr(1'h0, OFS_SCRATCH, rnd);
    end
    check(pci_reset_n, 32'h1);
    csr(1'h1, OFS_RETRY_LIMIT, 32'h0040_0000);
    csr(1'h0, OFS_RETRY_LIMIT, 32'h0040_0000);
    rnd = ($random(seed) | 32'h8) & ~32'h1800_0000;
    csr(1'h1, OFS_BUS_CONTROL, rnd);
    csr(1'h0, OFS_BUS_CONTROL, rnd & CTL_WMASK & ~32'h8);
    check(pci_reset_n, 32'h0);
    tick(10000);
    csr(1'h0, 12'h200, 32'h0);
    tick(1);
    check(irq_cnt, 32'h1);
    err_evt.tgt_abort = 1'h1;
    tick(1);
    err_evt.tgt_abort = 1'h0;
    csr(1'h0, OFS_ERROR_SUMMARY, 32'h9001);
    check(irq_cnt, 32'h1);
    csr(1'h1, OFS_ERROR_SUMMARY, 32'h1000);
    csr(1'h0, OFS_ERROR_SUMMARY, 32'h8001);
    csr(1'h1, OFS_ERROR_SUMMARY, 32'h8001);
    csr(1'h0, OFS_ERROR_SUMMARY, 32'h0);
    csr(1'h1, OFS_BUS_CONTROL, 32'h0085_5531);
    check(pci_reset_n, 32'h1);
    xlat(SPACE_SPARSE_MEM, 32'h2000_1234, 32'ha800_1234);
    xlat(SPACE_SPARSE_IO, 32'h4000_5678, 32'h5000_5678);
    xlat(SPACE_SPARSE_MEM, 32'h0700_0000, 32'h0700_0000);
    xlat(SPACE_CONFIG, 32'h0000_1230, 32'h0000_1231);
    check({15'h0, cfg}, {15'h0, 5'h0f, 3'h1, 3'h0, 1'h0, 5'h10});
    check(up_credit_avail, 32'h1);
    repeat (2) begin
      up_pkt_send = 1'h1;
      tick(1);
      up_pkt_send = 1'h0;
      check(up_credit_avail, 32'h0);
    end
    up_buf_free = 1'h1;
    tick(1);
    up_buf_free = 1'h0;
    check(up_credit_avail, 32'h1);
    cut_loop(1'h1);
    csr(1'h1, OFS_BUS_CONTROL, 32'h06fd_5435);
    tick(1);
    check({15'h0, cfg}, {15'h0, 5'h11, 3'h1, 3'h4, 1'h1, 5'h08});
    xlat(SPACE_SPARSE_MEM, 32'h2000_1234, 32'h2000_1234);
    cut_loop(1'h0);
    csr(1'h1, OFS_RETRY_LIMIT, 32'h2);
    pulse_disc(2);
    csr(1'h0, OFS_ERROR_SUMMARY, 32'h0);
    burst_done = 1'h1;
    tick(1);
    burst_done = 1'h0;
    pulse_disc(2);
    csr(1'h0, OFS_ERROR_SUMMARY, 32'h0);
    pulse_disc(1);
    csr(1'h0, OFS_ERROR_SUMMARY, 32'h2001);
    csr(1'h1, OFS_ERROR_SUMMARY, 32'h2001);
    tgt_burst_active = 1'h1;
    tick(8);
    tgt_lw_xfer = 1'h1;
    tick(1);
    tgt_lw_xfer = 1'h0;
    csr(1'h0, OFS_ERROR_SUMMARY, 32'h0);
    tick(10);
    tgt_burst_active = 1'h0;
    csr(1'h0, OFS_ERROR_SUMMARY, 32'h2_0001);
    check(irq_cnt, 32'h2);
    csr(1'h1, OFS_ERROR_SUMMARY, 32'h2_0001);
    dma_fail_addr = $random(seed);
    err_evt = 14'h37ff;
    serr_fire = 1'h1;
    tick(1);
    err_evt = '0;
    serr_fire = 1'h0;
    tick(8);
    check(fail_addr, dma_fail_addr);
    csr(1'h0, OFS_ERROR_SUMMARY, 32'h5_4fff);
    check(last_b, 32'h4_0fff);
    check(irq_cnt, 32'h3);
    check({28'h0, seen_gnt}, 32'hf);
    check(exp_q.size(), 32'h0);
    tally_and_finish();
  end
endmodule
